/* bench/clock_gate_ctrl_properties.sv */
// checker for the unit clock gating control ports
`timescale 1ns/100ps
module clock_gate_ctrl_properties (
	// clock and reset
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	// modes and units
	input wire sleep_mode,
	input wire deep_sleep_mode,
	input wire unit_req,
	input wire [3:0] unit_sel,
	input wire unit_fault,
	input wire port_a_clock_enable,
	input wire port_g_clock_enable,
	input wire ethernet_mac_clock_enable,
	input wire ethernet_phy_clock_enable,
	input wire irq
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
// ==========================================================
// properties
property p_mac_fault;
	unit_req && clk_en && unit_sel == 4'h7 && !ethernet_mac_clock_enable |=> unit_fault;
endproperty
a_mac_fault: assert property (p_mac_fault) else $error("mac fault missing");
property p_phy_fault;
	unit_req && clk_en && unit_sel == 4'h8 && !ethernet_phy_clock_enable |=> unit_fault;
endproperty
a_phy_fault: assert property (p_phy_fault) else $error("phy fault missing");
property p_open_ok;
	unit_req && clk_en && unit_sel == 4'h0 && port_a_clock_enable |=> !unit_fault;
endproperty
a_open_ok: assert property (p_open_ok) else $error("fault on clocked unit");
property p_unknown;
	unit_req && clk_en && unit_sel > 4'h8 |=> unit_fault;
endproperty
a_unknown: assert property (p_unknown) else $error("unknown unit no fault");
property p_cause;
	unit_fault && $past(clk_en) |-> $past(unit_req);
endproperty
a_cause: assert property (p_cause) else $error("fault without request");
property p_reset_clear;
	$rose(presetn) |-> !(port_a_clock_enable || port_g_clock_enable
		|| ethernet_mac_clock_enable || ethernet_phy_clock_enable);
endproperty
a_reset_clear: assert property (p_reset_clear) else $error("enable after reset");
// a change needs a write, a mode change or a restart two cycles before
property p_hold;
	(!psel && $stable(clk_en) && $stable(sleep_mode) && $stable(deep_sleep_mode))
		[*3] |-> $stable(port_g_clock_enable) && $stable(ethernet_phy_clock_enable);
endproperty
a_hold: assert property (p_hold) else $error("enable moved alone");
property p_rsvd;
	psel && !penable && !pwrite && clk_en && paddr == 12'h118
		|=> (prdata & 32'hAFFFFF80) == 32'h00000000;
endproperty
a_rsvd: assert property (p_rsvd) else $error("reserved bit read set");
property p_unmapped;
	psel && penable && paddr == 12'h300 |-> pslverr;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped no error");
c_fault: cover property (unit_fault);
c_irq: cover property (irq);
c_sleep: cover property (sleep_mode && ethernet_phy_clock_enable);
endmodule
bind clock_gate_ctrl clock_gate_ctrl_properties u_props (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pslverr(pslverr), .sleep_mode(sleep_mode),
	.deep_sleep_mode(deep_sleep_mode), .unit_req(unit_req), .unit_sel(unit_sel),
	.unit_fault(unit_fault), .port_a_clock_enable(port_a_clock_enable),
	.port_g_clock_enable(port_g_clock_enable),
	.ethernet_mac_clock_enable(ethernet_mac_clock_enable),
	.ethernet_phy_clock_enable(ethernet_phy_clock_enable), .irq(irq));

/* bench/tb.sv */
// self-checking bench for the unit clock gating control
`timescale 1ns/100ps
module tb;
reg pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, err;
reg [11:0] paddr = 0;
reg [31:0] pwdata = 0, rd;
reg sleep_mode = 0, deep_sleep_mode = 0, unit_req = 0;
reg [3:0] unit_sel = 0;
wire pready, pslverr, unit_fault, irq;
wire [31:0] prdata;
wire [8:0] en;
integer failures = 0, tests_run = 0;
`define CHK(n, e, a) begin tests_run = tests_run + 1; if ((a) !== (e)) begin \
	failures = failures + 1; $display("Error %s exp %0h got %0h", n, e, a); end end
always #10 pclk = ~pclk;
clock_gate_ctrl uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .sleep_mode(sleep_mode),
	.deep_sleep_mode(deep_sleep_mode), .unit_req(unit_req), .unit_sel(unit_sel),
	.unit_fault(unit_fault), .port_a_clock_enable(en[0]), .port_b_clock_enable(en[1]),
	.port_c_clock_enable(en[2]), .port_d_clock_enable(en[3]), .port_e_clock_enable(en[4]),
	.port_f_clock_enable(en[5]), .port_g_clock_enable(en[6]),
	.ethernet_mac_clock_enable(en[7]), .ethernet_phy_clock_enable(en[8]), .irq(irq));
// ==========================================================
// bus and unit tasks
task apb(input w, input [11:0] a, input [31:0] d);
	begin
	@(posedge pclk);
	psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	do @(posedge pclk); while (pready !== 1'b1);
	rd = prdata;
	err = pslverr;
	psel <= 0; penable <= 0;
	end
endtask
task acc(input [3:0] s, input e);
	begin
	@(posedge pclk);
	unit_req <= 1; unit_sel <= s;
	@(posedge pclk);
	unit_req <= 0;
	#1 `CHK("fault", e, unit_fault)
	end
endtask
task settle(input integer n);
	begin
	repeat (n) @(posedge pclk);
	#1;
	end
endtask
// ==========================================================
// scenarios
task t_bits;
	integer k;
	begin
	apb(0, 12'h118, 0); `CHK("reset rb", 32'h0, rd)
	apb(1, 12'h118, 32'hFFFFFFFF);
	apb(0, 12'h118, 0); `CHK("sleep rb", 32'h5000007F, rd)
	for (k = 0; k < 9; k = k + 1) begin
		apb(1, 12'h108, 32'h1 << (k < 7 ? k : 28 + 2 * (k - 7)));
		settle(1); `CHK("run en", 9'h1 << k, en)
	end
	end
endtask
task t_modes;
	begin
	apb(1, 12'h108, 32'h1); apb(1, 12'h118, 32'h40000040); apb(1, 12'h128, 0);
	@(posedge pclk); sleep_mode <= 1;
	settle(3); `CHK("no auto", 9'h001, en)
	apb(1, 12'h200, 1);
	settle(2); `CHK("sleep", 9'h140, en)
	@(posedge pclk); deep_sleep_mode <= 1;
	settle(3); `CHK("deep", 9'h000, en)
	@(posedge pclk); deep_sleep_mode <= 0; sleep_mode <= 0;
	settle(3); `CHK("run", 9'h001, en)
	end
endtask
task t_fault;
	begin
	acc(4'h0, 0);
	acc(4'h2, 1);
	acc(4'h7, 1);
	acc(4'h8, 1);
	acc(4'hF, 1);
	settle(1); `CHK("masked", 1'b0, irq)
	apb(0, 12'h204, 0); `CHK("status", 32'hF, rd)
	apb(0, 12'h210, 0); `CHK("fault info", 32'h10F, rd)
	apb(0, 12'h20C, 0); `CHK("mode status", 32'h00010000, rd)
	apb(1, 12'h208, 1); settle(1); `CHK("irq", 1'b1, irq)
	apb(1, 12'h204, 32'hF); settle(1); `CHK("cleared", 1'b0, irq)
	apb(0, 12'h300, 0); `CHK("slverr", 1'b1, err)
	`CHK("unmapped", 32'h0, rd)
	end
endtask
task t_freeze;
	begin
	@(posedge pclk); clk_en <= 0; sleep_mode <= 1;
	settle(3); `CHK("frozen", 9'h001, en)
	`CHK("stalled", 1'b0, pready)
	@(posedge pclk); clk_en <= 1;
	settle(3); `CHK("thawed", 9'h140, en)
	@(posedge pclk); sleep_mode <= 0;
	settle(3); `CHK("woken", 9'h001, en)
	end
endtask
task stop_test;
	begin
	$display("failures=%0d tests_run=%0d", failures, tests_run);
	if (failures == 0 && tests_run > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
	end
endtask
initial begin
	#200000;
	failures = failures + 1;
	stop_test;
end
initial begin
	repeat (10) @(posedge pclk);
	presetn <= 1;
	settle(1); `CHK("reset en", 9'h000, en)
	t_bits;
	t_modes;
	t_fault;
	t_freeze;
	stop_test;
end
endmodule

/* hdl/clock_gate_consts.vh */
// constants for the unit clock gating control block
`ifndef CLOCK_GATE_CONSTS_VH
`define CLOCK_GATE_CONSTS_VH

// ==========================================================
// register offsets (byte addresses, 12-bit window)
`define OFS_RUN_GATE 12'h108
`define OFS_SLEEP_GATE 12'h118
`define OFS_DEEP_GATE 12'h128
`define OFS_RUN_CFG 12'h200
`define OFS_INT_STATUS 12'h204
`define OFS_INT_MASK 12'h208
`define OFS_MODE_STATUS 12'h20C
`define OFS_FAULT_INFO 12'h210

// ==========================================================
// gating register fields
`define BIT_PORT_A 0
`define BIT_PORT_G 6
`define BIT_ETH_MAC 28
`define BIT_ETH_PHY 30
`define GATE_WMASK 32'h5000007F
`define GATE_RESET 32'h00000000

// ==========================================================
// run clock configuration fields
`define BIT_AUTO_GATING 0
`define RUN_CFG_RESET 32'h00000000

// ==========================================================
// interrupt status fields
`define INT_BIT_FAULT 0
`define INT_BIT_SLEEP 1
`define INT_BIT_DEEP 2
`define INT_BIT_WAKE 3
`define INT_WIDTH 4
`define INT_RESET 4'h0

// ==========================================================
// unit indices seen on the unit access port
`define UNIT_ETH_MAC 4'h7
`define UNIT_ETH_PHY 4'h8
`define UNIT_COUNT 9

`endif

/* hdl/clock_gate_ctrl.v */
// unit clock gating control with apb registers and mode selection
//
// Overview of operation
// - set bit clocks unit, clear bit stops it
// - access to unclocked unit raises bus fault
// - reset clears every gating bit
// - mode picks run, sleep or deep register
// - sleep registers used only with auto gating
// - bit 6 enables port g clock
// - reserved bits read zero, ignore writes
// - bit 30 enables ethernet phy clock
// - bit 28 enables ethernet mac clock
// - bits 0 to 5 enable ports a-f
`timescale 1ns/100ps
`include "clock_gate_consts.vh"

module clock_gate_ctrl (
	// clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire [31:0] prdata,
	output wire pslverr,
	// operating mode requests
	input wire sleep_mode,
	input wire deep_sleep_mode,
	// unit access check
	input wire unit_req,
	input wire [3:0] unit_sel,
	output wire unit_fault,
	// unit clock enables
	output wire port_a_clock_enable,
	output wire port_b_clock_enable,
	output wire port_c_clock_enable,
	output wire port_d_clock_enable,
	output wire port_e_clock_enable,
	output wire port_f_clock_enable,
	output wire port_g_clock_enable,
	output wire ethernet_mac_clock_enable,
	output wire ethernet_phy_clock_enable,
	// interrupt
	output wire irq
);

localparam [1:0] MODE_RUN = 2'h0;
localparam [1:0] MODE_SLEEP = 2'h1;
localparam [1:0] MODE_DEEP = 2'h2;

// ==========================================================
// apb decode
wire setup_phase;
wire access_phase;
wire wr_access;
reg addr_hit;

assign setup_phase = psel && !penable;
assign access_phase = psel && penable;
// a frozen block stretches the access instead of dropping it
assign pready = clk_en;
assign wr_access = access_phase && pwrite && clk_en;

always @* begin
	case (paddr)
		`OFS_RUN_GATE: addr_hit = 1'b1;
		`OFS_SLEEP_GATE: addr_hit = 1'b1;
		`OFS_DEEP_GATE: addr_hit = 1'b1;
		`OFS_RUN_CFG: addr_hit = 1'b1;
		`OFS_INT_STATUS: addr_hit = 1'b1;
		`OFS_INT_MASK: addr_hit = 1'b1;
		`OFS_MODE_STATUS: addr_hit = 1'b1;
		`OFS_FAULT_INFO: addr_hit = 1'b1;
		default: addr_hit = 1'b0;
	endcase
end

assign pslverr = access_phase && !addr_hit;

// ==========================================================
// gating registers
wire [31:0] run_unit_clock_gate_2;
wire [31:0] sleep_unit_clock_gate_2;
wire [31:0] deep_sleep_unit_clock_gate_2;
wire wr_run_gate;
wire wr_sleep_gate;
wire wr_deep_gate;

assign wr_run_gate = wr_access && (paddr == `OFS_RUN_GATE);
assign wr_sleep_gate = wr_access && (paddr == `OFS_SLEEP_GATE);
assign wr_deep_gate = wr_access && (paddr == `OFS_DEEP_GATE);

gate_reg u_run_gate (
	.pclk(pclk),
	.presetn(presetn),
	.clk_en(clk_en),
	.wr_en(wr_run_gate),
	.wdata(pwdata),
	.q(run_unit_clock_gate_2)
);

gate_reg u_sleep_gate (
	.pclk(pclk),
	.presetn(presetn),
	.clk_en(clk_en),
	.wr_en(wr_sleep_gate),
	.wdata(pwdata),
	.q(sleep_unit_clock_gate_2)
);

gate_reg u_deep_gate (
	.pclk(pclk),
	.presetn(presetn),
	.clk_en(clk_en),
	.wr_en(wr_deep_gate),
	.wdata(pwdata),
	.q(deep_sleep_unit_clock_gate_2)
);

// ==========================================================
// run clock configuration, only the auto gating select is kept
reg auto_gating_select_ff;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		auto_gating_select_ff <= 1'b0;
	end else if (wr_access && (paddr == `OFS_RUN_CFG)) begin
		auto_gating_select_ff <= pwdata[`BIT_AUTO_GATING];
	end
end

// ==========================================================
// operating mode tracking
reg [1:0] mode_ff;
reg [1:0] nxt_mode;

always @* begin
	if (deep_sleep_mode) begin
		nxt_mode = MODE_DEEP;
	end else if (sleep_mode) begin
		nxt_mode = MODE_SLEEP;
	end else begin
		nxt_mode = MODE_RUN;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		mode_ff <= MODE_RUN;
	end else if (clk_en) begin
		mode_ff <= nxt_mode;
	end
end

// ==========================================================
// enable selection by mode
reg [31:0] active_gate;

always @* begin
	case (mode_ff)
		MODE_RUN: begin
			active_gate = run_unit_clock_gate_2;
		end
		MODE_SLEEP: begin
			// without auto gating the run settings stay in force
			if (auto_gating_select_ff) begin
				active_gate = sleep_unit_clock_gate_2;
			end else begin
				active_gate = run_unit_clock_gate_2;
			end
		end
		MODE_DEEP: begin
			if (auto_gating_select_ff) begin
				active_gate = deep_sleep_unit_clock_gate_2;
			end else begin
				active_gate = run_unit_clock_gate_2;
			end
		end
		default: begin
			active_gate = run_unit_clock_gate_2;
		end
	endcase
end

// ports a..g, mac, phy in unit index order
wire [8:0] nxt_unit_en;
reg [8:0] unit_en_ff;

assign nxt_unit_en = {active_gate[`BIT_ETH_PHY],
	active_gate[`BIT_ETH_MAC],
	active_gate[`BIT_PORT_G],
	active_gate[`BIT_PORT_G-1:`BIT_PORT_A]};

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		unit_en_ff <= 9'h000;
	end else if (clk_en) begin
		unit_en_ff <= nxt_unit_en;
	end
end

assign port_a_clock_enable = unit_en_ff[0];
assign port_b_clock_enable = unit_en_ff[1];
assign port_c_clock_enable = unit_en_ff[2];
assign port_d_clock_enable = unit_en_ff[3];
assign port_e_clock_enable = unit_en_ff[4];
assign port_f_clock_enable = unit_en_ff[5];
assign port_g_clock_enable = unit_en_ff[6];
assign ethernet_mac_clock_enable = unit_en_ff[7];
assign ethernet_phy_clock_enable = unit_en_ff[8];

// ==========================================================
// unit access fault
wire unit_gated;
reg unit_fault_ff;
reg [3:0] fault_unit_ff;
reg fault_seen_ff;

unit_fault_check u_fault (
	.unit_sel(unit_sel),
	.unit_en(unit_en_ff),
	.gated(unit_gated)
);

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		unit_fault_ff <= 1'b0;
		fault_unit_ff <= 4'h0;
		fault_seen_ff <= 1'b0;
	end else if (clk_en) begin
		unit_fault_ff <= unit_req && unit_gated;
		if (unit_req && unit_gated) begin
			fault_unit_ff <= unit_sel;
			fault_seen_ff <= 1'b1;
		end
	end
end

assign unit_fault = unit_fault_ff;

// ==========================================================
// interrupt events, status and mask
wire [3:0] event_vec;
wire [3:0] int_w1c;
reg [3:0] int_status_ff;
reg [3:0] int_mask_ff;

assign event_vec[`INT_BIT_FAULT] = unit_fault_ff;
assign event_vec[`INT_BIT_SLEEP] = (mode_ff != MODE_SLEEP) && (nxt_mode == MODE_SLEEP);
assign event_vec[`INT_BIT_DEEP] = (mode_ff != MODE_DEEP) && (nxt_mode == MODE_DEEP);
assign event_vec[`INT_BIT_WAKE] = (mode_ff != MODE_RUN) && (nxt_mode == MODE_RUN);

assign int_w1c = (wr_access && (paddr == `OFS_INT_STATUS)) ? pwdata[3:0] : 4'h0;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		int_status_ff <= `INT_RESET;
		int_mask_ff <= `INT_RESET;
	end else if (clk_en) begin
		// a new event in the clearing cycle keeps its bit
		int_status_ff <= (int_status_ff & ~int_w1c) | event_vec;
		if (wr_access && (paddr == `OFS_INT_MASK)) begin
			int_mask_ff <= pwdata[3:0];
		end
	end
end

assign irq = |(int_status_ff & int_mask_ff);

// ==========================================================
// read data, captured in the setup cycle so it is a flop output
reg [31:0] rd_mux;
reg [31:0] prdata_ff;

always @* begin
	case (paddr)
		`OFS_RUN_GATE: rd_mux = run_unit_clock_gate_2;
		`OFS_SLEEP_GATE: rd_mux = sleep_unit_clock_gate_2;
		`OFS_DEEP_GATE: rd_mux = deep_sleep_unit_clock_gate_2;
		`OFS_RUN_CFG: rd_mux = {31'h00000000, auto_gating_select_ff};
		`OFS_INT_STATUS: rd_mux = {28'h0000000, int_status_ff};
		`OFS_INT_MASK: rd_mux = {28'h0000000, int_mask_ff};
		`OFS_MODE_STATUS: rd_mux = {7'h00, unit_en_ff, 14'h0000, mode_ff};
		`OFS_FAULT_INFO: rd_mux = {23'h000000, fault_seen_ff, 4'h0, fault_unit_ff};
		default: rd_mux = 32'h00000000;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata_ff <= 32'h00000000;
	end else if (clk_en && setup_phase && !pwrite) begin
		prdata_ff <= rd_mux;
	end
end

assign prdata = prdata_ff;

endmodule

/* hdl/gate_reg.v */
// one gating register, only documented control bits are stored
`timescale 1ns/100ps
`include "clock_gate_consts.vh"

module gate_reg (
	// clock and reset
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	// write port
	input wire wr_en,
	input wire [31:0] wdata,
	// contents
	output wire [31:0] q
);

localparam [31:0] WMASK = `GATE_WMASK;
localparam [31:0] RSTV = `GATE_RESET;

// ==========================================================
// per-bit storage
genvar i;
generate
	for (i = 0; i < 32; i = i + 1) begin : g_bit
		if (WMASK[i]) begin : g_rw
			reg bit_ff;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					bit_ff <= RSTV[i];
				end else if (clk_en && wr_en) begin
					bit_ff <= wdata[i];
				end
			end
			assign q[i] = bit_ff;
		end else begin : g_rsvd
			// reserved bits hold no flop: read zero, writes lost
			assign q[i] = 1'b0;
		end
	end
endgenerate

endmodule

/* hdl/unit_fault_check.v */
// decides whether an access to a unit meets a stopped clock
`timescale 1ns/100ps
`include "clock_gate_consts.vh"

module unit_fault_check (
	// unit access
	input wire [3:0] unit_sel,
	// active enables, ports a..g, mac, phy
	input wire [8:0] unit_en,
	// result
	output wire gated
);

// ==========================================================
// one-hot decode of the addressed unit
wire [8:0] hit;
genvar i;
generate
	for (i = 0; i < `UNIT_COUNT; i = i + 1) begin : g_hit
		assign hit[i] = ({28'h0000000, unit_sel} == i);
	end
endgenerate

// an unknown unit index has no clock at all, so it faults too
assign gated = ~|(hit & unit_en);

endmodule
